// ### common/intprio_pkg.sv
/*
  Constants for the interrupt priority register pair: APB offsets, field positions,
  reset values and priority codes.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package intprio_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] INTPRIO_UART_FAULT_OFS = 12'h000;
  localparam logic [11:0] INTPRIO_CAN_DMA_OFS = 12'h004;
  localparam logic [11:0] INTPRIO_REQ_STAT_OFS = 12'h008;
  localparam int INTPRIO_ADDR_W = 12;

  // ==========================================================
  // Field layout
  localparam int INTPRIO_FIELD_W = 3;
  localparam int INTPRIO_SRC_N = 7;
  localparam int INTPRIO_REG_W = 16;
  localparam int INTPRIO_POS_F2 = 8;
  localparam int INTPRIO_POS_F1 = 4;
  localparam int INTPRIO_POS_F0 = 0;
  localparam int INTPRIO_POS_F3 = 12;

  // ==========================================================
  // Priority codes
  localparam logic [2:0] INTPRIO_DISABLED = 3'h0;
  localparam logic [2:0] INTPRIO_LOWEST = 3'h1;
  localparam logic [2:0] INTPRIO_HIGHEST = 3'h7;
  localparam logic [2:0] INTPRIO_RESET = 3'h4;

  // Source order on the flattened vectors
  typedef enum logic [2:0] {
    INTPRIO_SRC_PWM_FAULT_B = 3'h0,
    INTPRIO_SRC_UART1_ERR = 3'h1,
    INTPRIO_SRC_UART2_ERR = 3'h2,
    INTPRIO_SRC_DMA6 = 3'h3,
    INTPRIO_SRC_DMA7 = 3'h4,
    INTPRIO_SRC_CAN1_TX = 3'h5,
    INTPRIO_SRC_CAN2_TX = 3'h6
  } intprio_src_t;

endpackage

// ### hdl/intprio_gate.sv
/*
  One source's priority presentation stage: registered level and gated request.
  Assumes request inputs already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module intprio_gate
  import intprio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [INTPRIO_FIELD_W-1:0] level,
  input wire logic req,
  output logic [INTPRIO_FIELD_W-1:0] level_q,
  output logic req_q
);

  // ==========================================================
  // Gating
  wire enabled = (level != INTPRIO_DISABLED);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      level_q <= INTPRIO_RESET;
      req_q <= 1'b0;
    end else begin
      level_q <= level;
      req_q <= req & enabled;
    end
  end

endmodule

// ### hdl/intprio_regs.sv
/*
  Two 16-bit priority registers on APB, driving per-source priority levels and
  gated requests toward the arbiter.
  Assumes a single 200 MHz clock, synchronous active-high reset, requests on sys_clk.
*/
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps

module intprio_regs
  import intprio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [INTPRIO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [INTPRIO_SRC_N-1:0] src_req,
  output logic [INTPRIO_SRC_N*INTPRIO_FIELD_W-1:0] src_level,
  output logic [INTPRIO_SRC_N-1:0] src_req_gated,
  output logic [INTPRIO_SRC_N-1:0] src_top_level
);

  // ==========================================================
  // Field storage, one per source
  logic [INTPRIO_FIELD_W-1:0] prio_q [INTPRIO_SRC_N];
  logic [INTPRIO_FIELD_W-1:0] level_out [INTPRIO_SRC_N];
  logic [INTPRIO_SRC_N-1:0] top_q;

  // ==========================================================
  // APB decode
  wire access = psel & penable;
  wire hit_a = (paddr == INTPRIO_UART_FAULT_OFS);
  wire hit_b = (paddr == INTPRIO_CAN_DMA_OFS);
  wire hit_s = (paddr == INTPRIO_REQ_STAT_OFS);
  wire mapped = hit_a | hit_b | hit_s;
  wire wr_a = access & pwrite & hit_a;
  wire wr_b = access & pwrite & hit_b;
  wire wr_err = access & (~mapped | (pwrite & hit_s));

  // Field positions in the 16-bit word per source
  function automatic int field_pos(input int s);
    case (s)
      0, 3: field_pos = INTPRIO_POS_F0;
      1, 4: field_pos = INTPRIO_POS_F1;
      2, 5: field_pos = INTPRIO_POS_F2;
      default: field_pos = INTPRIO_POS_F3;
    endcase
  endfunction

  // Read images; gaps stay zero
  logic [INTPRIO_REG_W-1:0] img_a;
  logic [INTPRIO_REG_W-1:0] img_b;
  always_comb begin
    img_a = '0;
    img_b = '0;
    for (int s = 0; s < 3; s++) begin
      img_a[field_pos(s) +: INTPRIO_FIELD_W] = prio_q[s];
    end
    for (int s = 3; s < INTPRIO_SRC_N; s++) begin
      img_b[field_pos(s) +: INTPRIO_FIELD_W] = prio_q[s];
    end
  end

  wire [31:0] rd_mux = hit_a ? {16'h0000, img_a} :
                       hit_b ? {16'h0000, img_b} :
                       hit_s ? {25'h0000000, src_req_gated} : 32'h00000000;

  // ==========================================================
  // Per-source fields
  genvar g;
  generate
    for (g = 0; g < INTPRIO_SRC_N; g++) begin : g_src
      localparam int P = field_pos(g);
      localparam int LANE = P / 8;
      wire wr_hit = (g < 3 ? wr_a : wr_b) & pstrb[LANE];
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          prio_q[g] <= INTPRIO_RESET;
        end else if (wr_hit) begin
          prio_q[g] <= pwdata[P +: INTPRIO_FIELD_W];
        end
      end
      intprio_gate u_gate (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .level(prio_q[g]),
        .req(src_req[g]),
        .level_q(level_out[g]),
        .req_q(src_req_gated[g])
      );
      assign src_level[g*INTPRIO_FIELD_W +: INTPRIO_FIELD_W] = level_out[g];
      // Top user level flag for the arbiter's fast path
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          top_q[g] <= 1'b0;
        end else begin
          top_q[g] <= (prio_q[g] == INTPRIO_HIGHEST);
        end
      end
    end
  endgenerate

  assign src_top_level = top_q;

  // ==========================================================
  // APB answer: one wait-free access phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (~mapped | (pwrite & hit_s));
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

endmodule

// ### tb/interrupt_priority_regs_tb.sv
/* Random APB bench for intprio_regs.
   Assumes pready within 50 clock cycles of raising penable. */
`timescale 1ns/1ps
module interrupt_priority_regs_tb;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d;
  logic [3:0] pstrb = 0, s;
  logic [6:0] src_req = 0, src_req_gated, src_top_level;
  logic [20:0] src_level;
  logic [15:0] m[2];
  int num_errors = 0, n_tests = 0, seed = 72592, i, j, k;
  intprio_regs uut(.*);
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) src_req <= 7'($random(seed));
  // ========
  // Bus and checks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    psel <= 1;
    {pwrite, paddr, pwdata, pstrb} <= {w, a, v, s};
    @(posedge sys_clk);
    penable <= 1;
    k = 0;
    // Request held until pready is seen high at a rising edge
    do @(posedge sys_clk); while (pready !== 1'b1 && ++k < 50);
    num_errors += int'(k == 50);
    {rd, err} = {prdata, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("tests=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    conclude;
  end
  // ========
  // Tests
  initial begin
    m = '{16'h0444, 16'h4444};
    repeat (8) @(posedge sys_clk);
    sys_rst <= 0;
    for (i = 0; i < 42; i++) begin
      j = i % 2;
      // Zero then all ones first: disabled and top codes
      d = i < 6 ? {32{i > 3}} : $random(seed);
      s = i < 6 ? 4'hf : 4'($random(seed));
      if (i > 1) apb(1, 12'(j * 4), d);
      if (i > 1) m[j] = {s[1] ? d[15:8] : m[j][15:8], s[0] ? d[7:0] : m[j][7:0]}
        & (j ? 16'h7777 : 16'h0777);
      apb(0, 12'(j * 4), 0);
      chk(rd, {16'h0, m[j]});
    end
    $display("field tests done");
    apb(1, 12'h00c, 32'hffffffff);
    chk({31'h0, err}, 1);
    $display("unmapped test done");
    conclude;
  end
endmodule

// ### tb/intprio_checker.sv
/* Port checker for intprio_regs.
   Assumes it is bound to intprio_regs. */
`timescale 1ns/1ps
module intprio_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic pready,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [6:0] src_req,
  input wire logic [6:0] src_req_gated,
  input wire logic [6:0] src_top_level,
  input wire logic [20:0] src_level
);
  // ========
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_lvl;
    !$past(sys_rst) && src_level[2:0] != 0 && $past(src_level[2:0]) != 0 && $past(src_req[0])
      |-> src_req_gated[0];
  endproperty
  a_lvl: assert property (p_lvl) else $error("request lost");
  property p_dis;
    src_level[2:0] == 0 && $past(src_level[2:0]) == 0 |-> !src_req_gated[0];
  endproperty
  a_dis: assert property (p_dis) else $error("disabled request seen");
  property p_rd1;
    pready && !pwrite && paddr == 12'h004 |-> prdata == {17'h0, src_level[20:18], 1'b0,
      src_level[17:15], 1'b0, src_level[14:12], 1'b0, src_level[11:9]};
  endproperty
  a_rd1: assert property (p_rd1) else $error("second register layout");
  property p_rd0;
    pready && !pwrite && paddr == 12'h000 |-> prdata == {21'h0, src_level[8:6], 1'b0,
      src_level[5:3], 1'b0, src_level[2:0]};
  endproperty
  a_rd0: assert property (p_rd0) else $error("first register layout");
  property p_top;
    $stable(src_level[20:18]) |-> src_top_level[6] == (src_level[20:18] == 3'h7);
  endproperty
  a_top: assert property (p_top) else $error("top level flag");
  property p_rst;
    $fell(sys_rst) |-> src_level == {7{3'h4}};
  endproperty
  a_rst: assert property (p_rst) else $error("reset level");
  c_rd: cover property (pready && !pwrite);
  c_top: cover property (src_top_level[6]);
  c_gate: cover property (src_req_gated[0]);
endmodule
bind intprio_regs intprio_checker chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .pready(pready),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .src_req(src_req),
  .src_req_gated(src_req_gated),
  .src_top_level(src_top_level),
  .src_level(src_level)
);
